/* File: bench/jds_robot_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Robot side: drives the active-low recipe triggers
module jds_robot_model #(
    parameter int NUM_REC = 6
) (
    // Clock and sequencer status
    input  wire logic               clk,
    input  wire logic               busy,
    // Triggers, active low, pulled up when released
    output logic [NUM_REC-1:0]      trigger_n
);
    logic releaseReq;
    logic waitExpired;

    initial begin
        trigger_n   = '1;
        releaseReq  = 1'b0;
        waitExpired = 1'b0;
    end

    // Release is requested mid-cycle by the bench and applied after the next edge
    always @(posedge clk) begin
        if (releaseReq) begin
            #1;
            trigger_n  = '1;
            releaseReq = 1'b0;
        end
    end

    // Wait for the cycle to end so the pulse is not wasted; early breaks that on purpose
    task automatic wait_idle(input bit early);
        int guard;
        guard = 0;
        while (!early && busy !== 1'b0 && guard < 4000) begin
            @(posedge clk);
            #1;
            guard++;
        end
        if (guard >= 4000) waitExpired = 1'b1;
        @(posedge clk);
        #1;
    endtask : wait_idle

    task automatic pulse(input int idx, input bit early, input int lowCycles);
        wait_idle(early);
        trigger_n[idx] = 1'b0;
        repeat (lowCycles) @(posedge clk);
        #1;
        trigger_n[idx] = 1'b1;
    endtask : pulse

    task automatic press(input int idx);
        wait_idle(1'b0);
        trigger_n[idx] = 1'b0;
    endtask : press
endmodule : jds_robot_model
`default_nettype wire

/* File: bench/jet_drop_cycle_sequencer_test.sv */
`timescale 1ns/1ns
`default_nettype none
module jet_drop_cycle_sequencer_test;
    // ==========================================
    // Shortened time base keeps the run small
    localparam int T   = 4;
    localparam int TPS = 3;
    localparam int NR  = jds_pkg::NUM_RECIPES;

    logic                        clk;
    logic                        rst;
    logic                        cfgWrEn;
    logic [2:0]                  cfgWrIdx;
    logic [jds_pkg::TIME_W-1:0]  cfgRefill;
    logic [jds_pkg::TIME_W-1:0]  cfgDwell;
    logic [jds_pkg::TIME_W-1:0]  cfgAddBase;
    logic [jds_pkg::TIME_W-1:0]  cfgAddIdle;
    logic [jds_pkg::SEC_W-1:0]   cfgIdleSec;
    logic [jds_pkg::COUNT_W-1:0] cfgCount;
    logic                        cfgMode;
    logic [NR-1:0]               trigger_n;
    logic                        jetDrive;
    logic                        busy;
    logic [2:0]                  activeRecipe;
    logic                        dropDone;
    logic [jds_pkg::SEC_W-1:0]   idleSeconds;
    logic [15:0]                 linkBaudDiv;
    logic [3:0]                  linkDataBits;
    logic                        linkParityEn;
    logic                        linkCtsEn;
    int                          errors;
    int                          comparisons;
    logic [31:0]                 lfsr;
    int                          rv[NR], dv[NR], av[NR], cv[NR];

    jds_sequencer #(.NUM_REC(NR), .TICK_CYCLES(T), .TICKS_PER_SEC(TPS)) dut_u (
        .clk(clk), .rst(rst), .cfgWrEn(cfgWrEn), .cfgWrIdx(cfgWrIdx), .cfgRefill(cfgRefill),
        .cfgDwell(cfgDwell), .cfgAddBase(cfgAddBase), .cfgAddIdle(cfgAddIdle),
        .cfgIdleSec(cfgIdleSec), .cfgCount(cfgCount), .cfgMode(cfgMode),
        .trigger_n(trigger_n), .jetDrive(jetDrive), .busy(busy),
        .activeRecipe(activeRecipe), .dropDone(dropDone), .idleSeconds(idleSeconds),
        .linkBaudDiv(linkBaudDiv), .linkDataBits(linkDataBits),
        .linkParityEn(linkParityEn), .linkCtsEn(linkCtsEn));

    jds_robot_model #(.NUM_REC(NR)) robot_u (.clk(clk), .busy(busy), .trigger_n(trigger_n));

    always #5 clk = ~clk;

    // ==========================================
    // Helpers
    function automatic int rand_below(input int n);
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return int'(lfsr[15:0]) % n;
    endfunction : rand_below

    function automatic int exp_refill(input int ref_t, input int comp);
        return (ref_t + comp) * T + 1;
    endfunction : exp_refill

    function automatic int exp_drops(input int cnt);
        return (cnt == 0) ? 1 : cnt;
    endfunction : exp_drops

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic program_recipe(input int idx, input int rf, input int dw, input int ab,
                                  input int ai, input int isec, input int cnt, input bit mode);
        @(posedge clk);
        #1;
        cfgWrEn    = 1'b1;
        cfgWrIdx   = 3'(idx);
        cfgRefill  = 16'(rf);
        cfgDwell   = 16'(dw);
        cfgAddBase = 16'(ab);
        cfgAddIdle = 16'(ai);
        cfgIdleSec = 16'(isec);
        cfgCount   = 16'(cnt);
        cfgMode    = mode;
        @(posedge clk);
        #1;
        cfgWrEn = 1'b0;
    endtask : program_recipe

    // Triggers a recipe and measures every refill and dwell phase of the run
    task automatic run_check(input int rec, input bit early, input int relAfter,
                             input int expDrops, input int rf, input int dw, input int comp);
        int guard, hi, lo, drops;
        bit started, prevJet;
        guard = 0;
        hi = 0;
        lo = 0;
        drops = 0;
        started = 1'b0;
        prevJet = 1'b0;
        fork
            if (relAfter == 0) robot_u.pulse(rec, 1'b0, 2);
            else robot_u.press(rec);
            while (guard < 3000) begin
                @(negedge clk);
                guard++;
                if (busy === 1'b1 && !started) begin
                    started = 1'b1;
                    check("activeRecipe", activeRecipe, rec);
                end
                if (dropDone === 1'b1) begin
                    check("dwell cycles", lo, dw * T + 1);
                    check("idleSeconds in run", idleSeconds, 0);
                    drops++;
                    lo = 0;
                    if (relAfter > 0 && drops == relAfter) robot_u.releaseReq = 1'b1;
                end
                if (jetDrive === 1'b1) begin
                    hi++;
                    if (early && drops == 0 && hi == 2) fork
                        robot_u.pulse(rec, 1'b1, 2);
                    join_none
                end else if (prevJet) begin
                    check("refill cycles", hi, exp_refill(rf, drops == 0 ? comp : 0));
                    hi = 0;
                    lo = 1;
                end else if (lo > 0) lo++;
                prevJet = jetDrive;
                if (started && busy === 1'b0) break;
            end
        join
        if (guard >= 3000) begin
            check("run finished", 0, 1);
            report_and_stop();
        end else begin
            check("robot wait expired", robot_u.waitExpired, 0);
            check("drop count", drops, expDrops);
            repeat (4) @(negedge clk);
            check("busy after run", busy, 0);
        end
    endtask : run_check

    // ==========================================
    // Main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        errors = 0;
        comparisons = 0;
        lfsr = 32'h4f69;
        cfgWrEn = 1'b0;
        cfgWrIdx = 3'h0;
        cfgRefill = 16'h0000;
        cfgDwell = 16'h0000;
        cfgAddBase = 16'h0000;
        cfgAddIdle = 16'h0000;
        cfgIdleSec = 16'h0000;
        cfgCount = 16'h0000;
        cfgMode = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        check("linkBaudDiv", linkBaudDiv, 16'h06C8);
        check("link framing", {linkDataBits, linkParityEn, linkCtsEn}, 6'h21);
        check("jetDrive after reset", jetDrive, 0);
        $display("test reset defaults done");
        // All recipes get random settings, which can repeat, before each pass's runs; the activeRecipe check shows a wrong pick
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < NR; i++) begin
                rv[i] = 1 + rand_below(3);
                dv[i] = 1 + rand_below(3);
                av[i] = rand_below(4);
                cv[i] = rand_below(4);
                program_recipe(i, rv[i], dv[i], av[i], 7, 16'hFFFF, cv[i],
                               jds_pkg::MODE_PULSE);
            end
            for (int i = 0; i < NR; i++) begin
                run_check(i, 1'b0, 0, exp_drops(cv[i]), rv[i], dv[i], av[i]);
            end
        end
        $display("test random pulse runs done");
        program_recipe(2, 2, 2, 1, 0, 16'hFFFF, 2, jds_pkg::MODE_PULSE);
        run_check(2, 1'b1, 0, 2, 2, 2, 1);
        $display("test trigger during run done");
        program_recipe(4, 1, 1, 2, 0, 16'hFFFF, 7, jds_pkg::MODE_LEVEL);
        run_check(4, 1'b0, 2, 3, 1, 1, 2);
        $display("test level mode done");
        program_recipe(5, 1, 2, 1, 3, 1, 1, jds_pkg::MODE_PULSE);
        repeat (60) @(posedge clk);
        #1;
        check("idle past threshold", idleSeconds > 16'h0001, 1);
        run_check(5, 1'b0, 0, 1, 1, 2, 3);
        $display("test idle addition done");
        report_and_stop();
    end
endmodule : jet_drop_cycle_sequencer_test
`default_nettype wire

/* File: hw/jds_pkg.sv */
package jds_pkg;
    // ==========================================================
    // Sizes
    localparam int NUM_RECIPES = 6;
    localparam int TIME_W      = 16;
    localparam int COUNT_W     = 16;
    localparam int SEC_W       = 16;

    // ==========================================================
    // Time base
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS       = 100000;
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    localparam int TICKS_PER_SEC = 1000000000 / TICK_NS;

    // ==========================================================
    // Serial link defaults
    localparam int       CLK_HZ       = 1000000000 / CLK_PERIOD_NS;
    localparam int       BAUD_RATE    = 57600;
    localparam int       BAUD_DIV_W   = 16;
    localparam bit [15:0] BAUD_DIV    = 16'(CLK_HZ / BAUD_RATE);
    localparam bit [3:0] DATA_BITS    = 4'h8;
    localparam bit       PARITY_EN    = 1'b0;
    localparam bit       CTS_EN       = 1'b1;

    // ==========================================================
    // Trigger modes
    localparam bit MODE_PULSE = 1'b0;
    localparam bit MODE_LEVEL = 1'b1;

    typedef struct packed {
        logic [TIME_W-1:0]  refill;
        logic [TIME_W-1:0]  dwell;
        logic [TIME_W-1:0]  addBase;
        logic [TIME_W-1:0]  addIdle;
        logic [SEC_W-1:0]   idleSec;
        logic [COUNT_W-1:0] count;
        logic               mode;
    } jds_recipe_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOAD,
        ST_REFILL,
        ST_DWELL
    } jds_state_t;
endpackage : jds_pkg

/* File: hw/jds_recipe_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface jds_recipe_if #(parameter int IDX_W = 3);
    logic                wrEn;
    logic [IDX_W-1:0]    wrIdx;
    jds_pkg::jds_recipe_t wrData;
    logic [IDX_W-1:0]    rdIdx;
    jds_pkg::jds_recipe_t rdData;

    modport mem  (input wrEn, wrIdx, wrData, rdIdx, output rdData);
    modport user (output wrEn, wrIdx, wrData, rdIdx, input rdData);
endinterface : jds_recipe_if
`default_nettype wire

/* File: hw/jds_recipe_mem.sv */
`timescale 1ns/1ns
`default_nettype none
module jds_recipe_mem #(
    parameter int DEPTH = jds_pkg::NUM_RECIPES
) (
    // Clock and reset
    input  wire logic     clk,
    input  wire logic     rst,
    // Recipe port
    jds_recipe_if.mem     rec
);
    jds_pkg::jds_recipe_t store_reg [DEPTH];
    jds_pkg::jds_recipe_t rdData_reg;
    jds_pkg::jds_recipe_t rdData_next;

    always_comb begin
        rdData_next = store_reg[rec.rdIdx];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                store_reg[i] <= '0;
            end
            rdData_reg <= '0;
        end else begin
            if (rec.wrEn) begin
                store_reg[rec.wrIdx] <= rec.wrData;
            end
            rdData_reg <= rdData_next;
        end
    end

    assign rec.rdData = rdData_reg;
endmodule : jds_recipe_mem
`default_nettype wire

/* File: hw/jds_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
module jds_sequencer #(
    parameter int NUM_REC       = jds_pkg::NUM_RECIPES,
    parameter int TICK_CYCLES   = jds_pkg::TICK_CYCLES,
    parameter int TICKS_PER_SEC = jds_pkg::TICKS_PER_SEC
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst,
    // Recipe programming
    input  wire logic                        cfgWrEn,
    input  wire logic [2:0]                  cfgWrIdx,
    input  wire logic [jds_pkg::TIME_W-1:0]  cfgRefill,
    input  wire logic [jds_pkg::TIME_W-1:0]  cfgDwell,
    input  wire logic [jds_pkg::TIME_W-1:0]  cfgAddBase,
    input  wire logic [jds_pkg::TIME_W-1:0]  cfgAddIdle,
    input  wire logic [jds_pkg::SEC_W-1:0]   cfgIdleSec,
    input  wire logic [jds_pkg::COUNT_W-1:0] cfgCount,
    input  wire logic                        cfgMode,
    // Triggers, active low
    input  wire logic [NUM_REC-1:0]          trigger_n,
    // Jet and status
    output logic                             jetDrive,
    output logic                             busy,
    output logic [2:0]                       activeRecipe,
    output logic                             dropDone,
    output logic [jds_pkg::SEC_W-1:0]        idleSeconds,
    // Serial link settings
    output logic [jds_pkg::BAUD_DIV_W-1:0]   linkBaudDiv,
    output logic [3:0]                       linkDataBits,
    output logic                             linkParityEn,
    output logic                             linkCtsEn
);
    // ==========================================================
    // Parameter checks
    if (NUM_REC < 1 || NUM_REC > 8) begin : g_badRec
        $error("NUM_REC must be 1 to 8");
    end
    if (TICK_CYCLES < 1 || TICKS_PER_SEC < 1) begin : g_badTick
        $error("tick counts must be at least 1");
    end

    localparam int PH_W = jds_pkg::TIME_W + 1;

    jds_recipe_if #(.IDX_W(3)) rec ();
    jds_recipe_mem #(.DEPTH(NUM_REC)) u_mem (.clk(clk), .rst(rst), .rec(rec));

    // Lowest-numbered requesting recipe wins a simultaneous start
    function automatic logic [2:0] pickRecipe(input logic [NUM_REC-1:0] req);
        logic [2:0] idx;
        idx = '0;
        for (int i = NUM_REC - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction : pickRecipe

    // ==========================================================
    // State
    jds_pkg::jds_state_t state_reg, state_next;
    logic [NUM_REC-1:0]           trigPrev_reg, trigPrev_next;
    logic [NUM_REC-1:0]           modeVec_reg, modeVec_next;
    logic [2:0]                   recipe_reg, recipe_next;
    logic                         first_reg, first_next;
    logic [jds_pkg::COUNT_W-1:0]  dropsLeft_reg, dropsLeft_next;
    logic [PH_W-1:0]              phaseTgt_reg, phaseTgt_next;
    logic [PH_W-1:0]              phaseCnt_reg, phaseCnt_next;
    logic [31:0]                  tickDiv_reg, tickDiv_next;
    logic [31:0]                  secDiv_reg, secDiv_next;
    logic [jds_pkg::SEC_W-1:0]    idleSec_reg, idleSec_next;
    logic                         jet_reg, jet_next;
    logic                         busy_reg, busy_next;
    logic                         done_reg, done_next;

    logic [NUM_REC-1:0] startReq;
    logic               tick;
    logic               phaseEnd;
    logic               idleLong;
    logic [PH_W-1:0]    comp;

    always_comb begin
        tick     = (tickDiv_reg == 32'(TICK_CYCLES - 1));
        phaseEnd = (phaseCnt_reg == phaseTgt_reg);
        idleLong = (idleSec_reg > rec.rdData.idleSec);
        for (int i = 0; i < NUM_REC; i++) begin
            startReq[i] = (modeVec_reg[i] == jds_pkg::MODE_LEVEL)
                        ? !trigger_n[i]
                        : (trigPrev_reg[i] && !trigger_n[i]);
        end
        // First drop only; a single-drop run is all first drops
        if (!first_reg) begin
            comp = '0;
        end else if (idleLong) begin
            comp = PH_W'(rec.rdData.addIdle);
        end else begin
            comp = PH_W'(rec.rdData.addBase);
        end

        rec.wrEn   = cfgWrEn;
        rec.wrIdx  = cfgWrIdx;
        rec.wrData = '{cfgRefill, cfgDwell, cfgAddBase, cfgAddIdle,
                       cfgIdleSec, cfgCount, cfgMode};
        rec.rdIdx  = (state_reg == jds_pkg::ST_IDLE) ? pickRecipe(startReq) : recipe_reg;

        state_next     = state_reg;
        trigPrev_next  = trigger_n;
        modeVec_next   = modeVec_reg;
        recipe_next    = recipe_reg;
        first_next     = first_reg;
        dropsLeft_next = dropsLeft_reg;
        phaseTgt_next  = phaseTgt_reg;
        phaseCnt_next  = phaseCnt_reg;
        tickDiv_next   = tick ? '0 : tickDiv_reg + 32'h1;
        secDiv_next    = secDiv_reg;
        idleSec_next   = idleSec_reg;
        jet_next       = 1'b0;
        busy_next      = 1'b1;
        done_next      = 1'b0;

        if (cfgWrEn && 32'(cfgWrIdx) < NUM_REC) begin
            modeVec_next[cfgWrIdx] = cfgMode;
        end

        case (state_reg)
            jds_pkg::ST_IDLE: begin
                busy_next = 1'b0;
                if (tick) begin
                    if (secDiv_reg == 32'(TICKS_PER_SEC - 1)) begin
                        secDiv_next = '0;
                        if (idleSec_reg != '1) begin
                            idleSec_next = idleSec_reg + 1'b1;
                        end
                    end else begin
                        secDiv_next = secDiv_reg + 32'h1;
                    end
                end
                if (|startReq) begin
                    state_next  = jds_pkg::ST_LOAD;
                    recipe_next = pickRecipe(startReq);
                    first_next  = 1'b1;
                    busy_next   = 1'b1;
                end
            end
            jds_pkg::ST_LOAD: begin
                // Recipe words arrive here; count zero still gives one drop
                if (first_reg) begin
                    dropsLeft_next = (rec.rdData.count == '0) ? 16'h1 : rec.rdData.count;
                end
                phaseTgt_next = PH_W'(rec.rdData.refill) + comp;
                phaseCnt_next = '0;
                tickDiv_next  = '0;
                idleSec_next  = '0;
                secDiv_next   = '0;
                jet_next      = 1'b1;
                state_next    = jds_pkg::ST_REFILL;
            end
            jds_pkg::ST_REFILL: begin
                jet_next = 1'b1;
                if (phaseEnd) begin
                    state_next    = jds_pkg::ST_DWELL;
                    phaseTgt_next = PH_W'(rec.rdData.dwell);
                    phaseCnt_next = '0;
                    tickDiv_next  = '0;
                    jet_next      = 1'b0;
                end else if (tick) begin
                    phaseCnt_next = phaseCnt_reg + 1'b1;
                end
            end
            default: begin
                // Edges seen while running are absorbed by trigPrev
                if (phaseEnd) begin
                    done_next  = 1'b1;
                    first_next = 1'b0;
                    if (rec.rdData.mode == jds_pkg::MODE_LEVEL) begin
                        state_next = trigger_n[recipe_reg] ? jds_pkg::ST_IDLE
                                                           : jds_pkg::ST_LOAD;
                    end else if (dropsLeft_reg > 16'h1) begin
                        dropsLeft_next = dropsLeft_reg - 1'b1;
                        state_next     = jds_pkg::ST_LOAD;
                    end else begin
                        state_next = jds_pkg::ST_IDLE;
                    end
                    busy_next = (state_next != jds_pkg::ST_IDLE);
                end else if (tick) begin
                    phaseCnt_next = phaseCnt_reg + 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg     <= jds_pkg::ST_IDLE;
            trigPrev_reg  <= '1;
            modeVec_reg   <= '0;
            recipe_reg    <= '0;
            first_reg     <= 1'b0;
            dropsLeft_reg <= '0;
            phaseTgt_reg  <= '0;
            phaseCnt_reg  <= '0;
            tickDiv_reg   <= '0;
            secDiv_reg    <= '0;
            idleSec_reg   <= '0;
            jet_reg       <= 1'b0;
            busy_reg      <= 1'b0;
            done_reg      <= 1'b0;
        end else begin
            state_reg     <= state_next;
            trigPrev_reg  <= trigPrev_next;
            modeVec_reg   <= modeVec_next;
            recipe_reg    <= recipe_next;
            first_reg     <= first_next;
            dropsLeft_reg <= dropsLeft_next;
            phaseTgt_reg  <= phaseTgt_next;
            phaseCnt_reg  <= phaseCnt_next;
            tickDiv_reg   <= tickDiv_next;
            secDiv_reg    <= secDiv_next;
            idleSec_reg   <= idleSec_next;
            jet_reg       <= jet_next;
            busy_reg      <= busy_next;
            done_reg      <= done_next;
        end
    end

    // ==========================================================
    // Serial link defaults; nothing here rewrites them yet
    logic [jds_pkg::BAUD_DIV_W-1:0] baud_reg;
    logic [3:0]                     bits_reg;
    logic                           par_reg;
    logic                           cts_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            baud_reg <= jds_pkg::BAUD_DIV;
            bits_reg <= jds_pkg::DATA_BITS;
            par_reg  <= jds_pkg::PARITY_EN;
            cts_reg  <= jds_pkg::CTS_EN;
        end else begin
            baud_reg <= baud_reg;
            bits_reg <= bits_reg;
            par_reg  <= par_reg;
            cts_reg  <= cts_reg;
        end
    end

    assign jetDrive     = jet_reg;
    assign busy         = busy_reg;
    assign activeRecipe = recipe_reg;
    assign dropDone     = done_reg;
    assign idleSeconds  = idleSec_reg;
    assign linkBaudDiv  = baud_reg;
    assign linkDataBits = bits_reg;
    assign linkParityEn = par_reg;
    assign linkCtsEn    = cts_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_refillDone;
        state_reg == jds_pkg::ST_REFILL && phaseEnd;
    endsequence
    sequence s_dwellPulseLast;
        state_reg == jds_pkg::ST_DWELL && phaseEnd
            && rec.rdData.mode == jds_pkg::MODE_PULSE && dropsLeft_reg == 16'h1;
    endsequence

    a_drive_in_refill: assert property (
        state_reg == jds_pkg::ST_REFILL |-> jetDrive && busy)
        else $error("jet drive not on during refill");
    a_dwell_after_refill: assert property (
        s_refillDone |=> state_reg == jds_pkg::ST_DWELL && !jetDrive)
        else $error("dwell did not follow refill");
    a_start_recipe: assert property (
        state_reg == jds_pkg::ST_IDLE && |startReq |=>
            state_reg == jds_pkg::ST_LOAD && recipe_reg == $past(rec.rdIdx))
        else $error("trigger did not start its recipe");
    a_busy_no_switch: assert property (
        state_reg != jds_pkg::ST_IDLE |=> $stable(recipe_reg))
        else $error("recipe changed mid-run");
    a_load_comp: assert property (
        state_reg == jds_pkg::ST_LOAD |=> idleSeconds == '0 &&
            phaseTgt_reg == PH_W'($past(rec.rdData.refill)) + $past(comp))
        else $error("refill target or idle clear wrong");
    a_run_ends: assert property (
        s_dwellPulseLast |=> state_reg == jds_pkg::ST_IDLE && !busy && !jetDrive)
        else $error("pulse run did not end after its count");
    a_level_stop: assert property (
        state_reg == jds_pkg::ST_DWELL && phaseEnd && rec.rdData.mode == jds_pkg::MODE_LEVEL
            && trigger_n[recipe_reg] |=> state_reg == jds_pkg::ST_IDLE)
        else $error("level run kept going after release");
    a_later_no_comp: assert property (
        state_reg == jds_pkg::ST_LOAD && !first_reg |=>
            phaseTgt_reg == PH_W'($past(rec.rdData.refill)))
        else $error("later drop got a first-drop addition");
    a_phase_tick: assert property (
        state_reg == jds_pkg::ST_REFILL && !phaseEnd && !tick |=> $stable(phaseCnt_reg))
        else $error("phase counted without a tick");
    a_link_default: assert property (
        linkBaudDiv == jds_pkg::BAUD_DIV && linkDataBits == jds_pkg::DATA_BITS
            && !linkParityEn && linkCtsEn)
        else $error("serial defaults lost");
endmodule : jds_sequencer
`default_nettype wire
